// ===== fault_gpio_pkg.sv
// Shared constants, types and threshold tables for the fault status and pin control bank
package fault_gpio_pkg;

   localparam int NUM_CHANNELS = 8;
   localparam int NUM_PINS = 4;
   localparam int LEVEL_W = 10;

   typedef logic [LEVEL_W-1:0] level_t;
   typedef logic [2:0] threshold_code_t;
   typedef logic [7:0] byte_t;
   typedef logic [NUM_CHANNELS-1:0] channel_vec_t;
   typedef logic [NUM_PINS-1:0] pin_vec_t;
   typedef level_t [NUM_CHANNELS-1:0] level_bus_t;
   typedef level_t threshold_table_t [0:7];

   // Register offsets
   localparam byte_t ADDR_POS_STATUS = 8'h12;
   localparam byte_t ADDR_NEG_STATUS = 8'h13;
   localparam byte_t ADDR_PIN_CTRL = 8'h14;

   // Reset values and read answers
   localparam byte_t STATUS_RESET = 8'h00;
   localparam byte_t PIN_CTRL_RESET = 8'h0F;
   localparam byte_t READ_UNMAPPED = 8'h00;

   // Field positions inside the pin control register
   localparam int DIR_LSB = 0;
   localparam int DATA_LSB = 4;

   // Input levels are codes in thousandths of full scale
   localparam level_t FULL_SCALE = 10'h3E8;

   // High side: 95, 92.5, 90, 87.5, 85, 80, 75, 70 percent
   localparam threshold_table_t HIGH_THRESHOLD = '{
      10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
   // Low side: 5, 7.5, 10, 12.5, 15, 20, 25, 30 percent
   localparam threshold_table_t LOW_THRESHOLD = '{
      10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C};

   // Out of range when above the high side or below the low side
   function automatic logic over_threshold(input level_t level, input threshold_code_t sel);
      return (level > HIGH_THRESHOLD[sel]) || (level < LOW_THRESHOLD[sel]);
   endfunction : over_threshold

endpackage : fault_gpio_pkg

// ===== fault_if.sv
// Signals between the register bank and the threshold comparator bank
interface fault_if;
   import fault_gpio_pkg::*;

   logic ce;
   threshold_code_t comparator_threshold_select;
   level_bus_t positive_level;
   level_bus_t negative_level;
   channel_vec_t channel_positive_over_threshold;
   channel_vec_t channel_negative_over_threshold;

   modport bank (
      output ce, comparator_threshold_select, positive_level, negative_level,
      input channel_positive_over_threshold, channel_negative_over_threshold
   );

   modport comparator (
      input ce, comparator_threshold_select, positive_level, negative_level,
      output channel_positive_over_threshold, channel_negative_over_threshold
   );

endinterface : fault_if

// ===== fault_comparator.sv
// Per-channel window comparators feeding the fault status bits
module fault_comparator
   import fault_gpio_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Levels in, fault flags out
   fault_if.comparator fi
);

   typedef struct packed {
      channel_vec_t pos_fault;
      channel_vec_t neg_fault;
   } cmp_state_t;

   localparam cmp_state_t CMP_RESET = '{pos_fault: STATUS_RESET, neg_fault: STATUS_RESET};

   cmp_state_t state;
   cmp_state_t next_state;
   channel_vec_t raw_pos;
   channel_vec_t raw_neg;

   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
      // Each pin is held against the pair chosen by the threshold code
      assign raw_pos[ch] = over_threshold(fi.positive_level[ch], fi.comparator_threshold_select); // [R5]
      assign raw_neg[ch] = over_threshold(fi.negative_level[ch], fi.comparator_threshold_select); // [R5]
   end

   always_comb begin
      next_state = state;
      // Flags follow the inputs every cycle that ce is high; nothing is held once the input returns
      next_state.pos_fault = raw_pos; // [R2]
      next_state.neg_fault = raw_neg; // [R4]
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CMP_RESET;
      end else if (fi.ce) begin
         state <= next_state;
      end
   end

   assign fi.channel_positive_over_threshold = state.pos_fault;
   assign fi.channel_negative_over_threshold = state.neg_fault;

endmodule : fault_comparator

// ===== fault_status_and_gpio_regs.sv
// Fault status registers and general-purpose pin control register with its pin drivers
// Notes on behaviour
// [R1] The positive-input fault status register sits at 0x12, is read-only, resets to zero, bit n-1 is channel n.
// [R2] A positive-input fault bit reads 1 while that channel's positive pin is beyond the threshold, else 0.
// [R3] The negative-input fault status register sits at 0x13, is read-only, resets to zero, bit n-1 is channel n.
// [R4] A negative-input fault bit reads 1 while that channel's negative pin is beyond the threshold, else 0.
// [R5] Every fault bit comes from comparing its pin level with the threshold pair picked by the threshold code.
// [R6] The pin control register sits at 0x14 and resets to 0x0F, steering direction and level of four pins.
// [R7] Bits 3 to 0 pick each pin's direction, 0 for output and 1 for input, and all pins leave reset as inputs.
// [R8] Reading bits 7 to 4 returns the actual pin levels whatever the direction.
// [R9] Writing the data bits sets the driven level of every pin whose direction is output.
// [R10] Writing the data bits leaves pins set as inputs untouched, and they still report their outside level.
// [R11] The three-bit threshold code picks paired high and low limits from 95/5 percent down to 70/30 percent.
// [R12] Fault bits track the comparators without latching, and writes to the status registers are ignored.
module fault_status_and_gpio_regs
   import fault_gpio_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // Register access port
   input wire byte_t REG_ADDR,
   input wire byte_t REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output byte_t REG_RDATA,
   output logic REG_RVALID,
   // Fault comparator inputs
   input wire threshold_code_t COMPARATOR_THRESHOLD_SELECT,
   input wire level_bus_t POSITIVE_LEVEL,
   input wire level_bus_t NEGATIVE_LEVEL,
   // General-purpose pins
   input wire pin_vec_t PIN_IN,
   output pin_vec_t PIN_OUT,
   output pin_vec_t PIN_OE
);

   typedef struct packed {
      pin_vec_t pin_direction_field;
      pin_vec_t drive_enable;
      pin_vec_t pin_data_field;
      byte_t read_data;
      logic read_valid;
   } bank_state_t;

   localparam pin_vec_t DIR_RESET = PIN_CTRL_RESET[DIR_LSB +: NUM_PINS];
   localparam pin_vec_t DATA_RESET = PIN_CTRL_RESET[DATA_LSB +: NUM_PINS];

   localparam bank_state_t BANK_RESET = '{
      pin_direction_field: DIR_RESET,
      drive_enable: ~DIR_RESET,
      pin_data_field: DATA_RESET,
      read_data: READ_UNMAPPED,
      read_valid: 1'b0
   };

   bank_state_t state;
   bank_state_t next_state;
   pin_vec_t write_dir;
   pin_vec_t write_data;

   fault_if fi ();

   fault_comparator u_comparator (
      .mclk (MCLK),
      .rst (RST),
      .fi (fi.comparator)
   );

   assign fi.ce = CE;
   assign fi.comparator_threshold_select = COMPARATOR_THRESHOLD_SELECT; // [R11]
   assign fi.positive_level = POSITIVE_LEVEL;
   assign fi.negative_level = NEGATIVE_LEVEL;

   assign write_dir = REG_WDATA[DIR_LSB +: NUM_PINS];
   assign write_data = REG_WDATA[DATA_LSB +: NUM_PINS];

   always_comb begin
      next_state = state;
      next_state.read_valid = 1'b0;
      if (REG_RD) begin
         next_state.read_valid = 1'b1;
         case (REG_ADDR)
            ADDR_POS_STATUS: begin
               next_state.read_data = fi.channel_positive_over_threshold; // [R1]
            end
            ADDR_NEG_STATUS: begin
               next_state.read_data = fi.channel_negative_over_threshold; // [R3]
            end
            ADDR_PIN_CTRL: begin
               // Data half shows the pins themselves, so an output shorted outside reads its true level
               next_state.read_data = {PIN_IN, state.pin_direction_field}; // [R8]
            end
            default: begin
               next_state.read_data = READ_UNMAPPED;
            end
         endcase
      end
      // Status offsets take no write: only the pin control offset is decoded for writes
      if (REG_WR && (REG_ADDR == ADDR_PIN_CTRL)) begin // [R12]
         next_state.pin_direction_field = write_dir; // [R7]
         next_state.drive_enable = ~write_dir; // [R7]
         // Output pins take the new level; input pins keep their old latch
         next_state.pin_data_field = (state.pin_data_field & write_dir) | (write_data & ~write_dir); // [R9] [R10]
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= BANK_RESET; // [R6]
      end else if (CE) begin
         state <= next_state;
      end
   end

   assign REG_RDATA = state.read_data;
   assign REG_RVALID = state.read_valid;
   assign PIN_OUT = state.pin_data_field;
   assign PIN_OE = state.drive_enable;

   // Reference outcome of each comparator, for the checks below
   channel_vec_t expect_pos;
   channel_vec_t expect_neg;

   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_expect
      assign expect_pos[ch] = (POSITIVE_LEVEL[ch] > HIGH_THRESHOLD[COMPARATOR_THRESHOLD_SELECT])
         || (POSITIVE_LEVEL[ch] < LOW_THRESHOLD[COMPARATOR_THRESHOLD_SELECT]);
      assign expect_neg[ch] = (NEGATIVE_LEVEL[ch] > HIGH_THRESHOLD[COMPARATOR_THRESHOLD_SELECT])
         || (NEGATIVE_LEVEL[ch] < LOW_THRESHOLD[COMPARATOR_THRESHOLD_SELECT]);
   end

   logic read_pos;
   logic read_neg;
   logic read_ctrl;
   logic write_ctrl;
   logic write_status;

   assign read_pos = CE && REG_RD && (REG_ADDR == ADDR_POS_STATUS);
   assign read_neg = CE && REG_RD && (REG_ADDR == ADDR_NEG_STATUS);
   assign read_ctrl = CE && REG_RD && (REG_ADDR == ADDR_PIN_CTRL);
   assign write_ctrl = CE && REG_WR && (REG_ADDR == ADDR_PIN_CTRL);
   assign write_status = CE && REG_WR && ((REG_ADDR == ADDR_POS_STATUS) || (REG_ADDR == ADDR_NEG_STATUS));

   a_status_reset_zero : assert property ( // [R1] [R3]
      @(posedge MCLK) disable iff (RST)
      $fell(RST) |-> (fi.channel_positive_over_threshold == STATUS_RESET)
         && (fi.channel_negative_over_threshold == STATUS_RESET))
      else $error("fault status not zero after reset");

   a_pos_read_map : assert property ( // [R1]
      @(posedge MCLK) disable iff (RST)
      read_pos |=> REG_RVALID && (REG_RDATA == $past(fi.channel_positive_over_threshold)))
      else $error("positive status read returned wrong data");

   a_neg_read_map : assert property ( // [R3]
      @(posedge MCLK) disable iff (RST)
      read_neg |=> REG_RVALID && (REG_RDATA == $past(fi.channel_negative_over_threshold)))
      else $error("negative status read returned wrong data");

   a_pos_fault_track : assert property ( // [R2]
      @(posedge MCLK) disable iff (RST)
      CE |=> fi.channel_positive_over_threshold == $past(expect_pos))
      else $error("positive fault bit does not follow its input");

   a_neg_fault_track : assert property ( // [R4]
      @(posedge MCLK) disable iff (RST)
      CE |=> fi.channel_negative_over_threshold == $past(expect_neg))
      else $error("negative fault bit does not follow its input");

   a_select_steers_limit : assert property ( // [R5]
      @(posedge MCLK) disable iff (RST)
      CE && (COMPARATOR_THRESHOLD_SELECT == 3'h7) && (POSITIVE_LEVEL[0] == 10'h2BD)
         ##1 CE && (COMPARATOR_THRESHOLD_SELECT == 3'h0) && (POSITIVE_LEVEL[0] == 10'h2BD)
      |-> fi.channel_positive_over_threshold[0] ##1 !fi.channel_positive_over_threshold[0])
      else $error("threshold code does not steer the comparator");

   a_code_zero_edges : assert property ( // [R11]
      @(posedge MCLK) disable iff (RST)
      CE && (COMPARATOR_THRESHOLD_SELECT == 3'h0) && (NEGATIVE_LEVEL[7] == 10'h3B6)
      |=> !fi.channel_negative_over_threshold[7])
      else $error("level equal to the high limit flagged as fault");

   a_code_seven_low : assert property ( // [R11]
      @(posedge MCLK) disable iff (RST)
      CE && (COMPARATOR_THRESHOLD_SELECT == 3'h7) && (NEGATIVE_LEVEL[2] == 10'h12B)
      |=> fi.channel_negative_over_threshold[2])
      else $error("level under the low limit not flagged");

   a_no_latch_clear : assert property ( // [R12]
      @(posedge MCLK) disable iff (RST)
      fi.channel_positive_over_threshold[0] && CE && !expect_pos[0]
      |=> !fi.channel_positive_over_threshold[0])
      else $error("fault bit held after its input recovered");

   a_status_write_ignored : assert property ( // [R12]
      @(posedge MCLK) disable iff (RST)
      write_status && !write_ctrl |=> $stable(PIN_OE) && $stable(PIN_OUT))
      else $error("write to a status offset changed pin control");

   a_pin_reset_inputs : assert property ( // [R6] [R7]
      @(posedge MCLK) disable iff (RST)
      $fell(RST) |-> (PIN_OE == ~DIR_RESET) && (PIN_OUT == DATA_RESET))
      else $error("pins not released from reset as inputs");

   a_ctrl_read_back : assert property ( // [R6] [R8]
      @(posedge MCLK) disable iff (RST)
      read_ctrl |=> REG_RVALID
         && (REG_RDATA[DATA_LSB +: NUM_PINS] == $past(PIN_IN))
         && (REG_RDATA[DIR_LSB +: NUM_PINS] == ~$past(PIN_OE)))
      else $error("pin control read back wrong");

   a_dir_write : assert property ( // [R7]
      @(posedge MCLK) disable iff (RST)
      write_ctrl |=> PIN_OE == ~$past(write_dir))
      else $error("direction write not applied");

   a_out_level_write : assert property ( // [R9]
      @(posedge MCLK) disable iff (RST)
      write_ctrl |=> (PIN_OUT & PIN_OE) == ($past(write_data) & PIN_OE))
      else $error("output pin level not set by write");

   a_input_untouched : assert property ( // [R10]
      @(posedge MCLK) disable iff (RST)
      write_ctrl |=> (PIN_OUT & ~PIN_OE) == ($past(PIN_OUT) & ~PIN_OE))
      else $error("write changed latch of an input pin");

   a_unmapped_zero : assert property (
      @(posedge MCLK) disable iff (RST)
      CE && REG_RD && (REG_ADDR > ADDR_PIN_CTRL) |=> REG_RVALID && (REG_RDATA == READ_UNMAPPED))
      else $error("unmapped read not zero");

   a_freeze_hold : assert property (
      @(posedge MCLK) disable iff (RST)
      !CE |=> $stable(REG_RDATA) && $stable(REG_RVALID) && $stable(PIN_OUT) && $stable(PIN_OE))
      else $error("state moved with clock enable low");

   // Reset checks run without the reset as a disable, or they could never fire
   a_reset_port_idle : assert property ( // [R6] [R7]
      @(posedge MCLK)
      RST |=> !REG_RVALID && (REG_RDATA == READ_UNMAPPED)
         && (PIN_OE == ~DIR_RESET) && (PIN_OUT == DATA_RESET))
      else $error("read port or pin control not at reset value");

   a_reset_status_clear : assert property ( // [R1] [R3]
      @(posedge MCLK)
      RST |=> (fi.channel_positive_over_threshold == STATUS_RESET)
         && (fi.channel_negative_over_threshold == STATUS_RESET))
      else $error("fault status not cleared by reset");

   a_status_write_inert : assert property ( // [R12]
      @(posedge MCLK) disable iff (RST)
      write_status |=> (fi.channel_positive_over_threshold == $past(expect_pos))
         && (fi.channel_negative_over_threshold == $past(expect_neg)))
      else $error("write to a status offset disturbed the fault bits");

   a_neg_latch_clear : assert property ( // [R12]
      @(posedge MCLK) disable iff (RST)
      fi.channel_negative_over_threshold[2] && CE && !expect_neg[2]
      |=> !fi.channel_negative_over_threshold[2])
      else $error("negative fault bit held after its input recovered");

   a_pos_limit_equal : assert property ( // [R11]
      @(posedge MCLK) disable iff (RST)
      CE && (POSITIVE_LEVEL[1] == HIGH_THRESHOLD[COMPARATOR_THRESHOLD_SELECT])
      |=> !fi.channel_positive_over_threshold[1])
      else $error("positive level at the high limit flagged as fault");

   a_neg_limit_equal : assert property ( // [R11]
      @(posedge MCLK) disable iff (RST)
      CE && (NEGATIVE_LEVEL[3] == LOW_THRESHOLD[COMPARATOR_THRESHOLD_SELECT])
      |=> !fi.channel_negative_over_threshold[3])
      else $error("negative level at the low limit flagged as fault");

   a_neg_under_low : assert property ( // [R4]
      @(posedge MCLK) disable iff (RST)
      CE && (NEGATIVE_LEVEL[2] < LOW_THRESHOLD[COMPARATOR_THRESHOLD_SELECT])
      |=> fi.channel_negative_over_threshold[2])
      else $error("negative level under the low limit not flagged");

   a_read_data_hold : assert property (
      @(posedge MCLK) disable iff (RST)
      CE && !REG_RD |=> $stable(REG_RDATA) && !REG_RVALID)
      else $error("read port moved without a read");

   a_ctrl_write_only : assert property ( // [R7] [R9] [R10]
      @(posedge MCLK) disable iff (RST)
      CE && !write_ctrl |=> $stable(PIN_OE) && $stable(PIN_OUT))
      else $error("pin control moved without a write");

   c_fault_seen : cover property (
      @(posedge MCLK) disable iff (RST)
      read_pos ##1 (REG_RDATA != STATUS_RESET));

   c_fault_clears : cover property (
      @(posedge MCLK) disable iff (RST)
      fi.channel_negative_over_threshold[0] ##[1:20] !fi.channel_negative_over_threshold[0]);

   c_drive_output : cover property (
      @(posedge MCLK) disable iff (RST)
      write_ctrl && (write_dir != DIR_RESET) ##1 (PIN_OE != '0));

   c_read_pins : cover property (
      @(posedge MCLK) disable iff (RST)
      write_ctrl ##[1:10] read_ctrl);

   c_frozen_read : cover property (
      @(posedge MCLK) disable iff (RST)
      !CE && REG_RD ##1 !REG_RVALID);

endmodule : fault_status_and_gpio_regs

// ===== pin_world.sv
// Outside world of the four general-purpose pins, resolving each wire from the block and a source
module pin_world
   import fault_gpio_pkg::*;
(
   // Drive from the block
   input wire pin_vec_t pin_out,
   input wire pin_vec_t pin_oe,
   // Outside source, seen only on pins the block leaves alone
   input wire pin_vec_t ext_level,
   // Resolved wire levels
   output pin_vec_t pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // No pull on these pins, so a released pin shows the outside source and never a stale drive
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule : pin_world

// ===== fault_status_and_gpio_regs_tb_top.sv
// Self-checking testbench for the fault status and pin control register bank
module fault_status_and_gpio_regs_tb_top
   import fault_gpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HI_LIM [8] = '{950, 925, 900, 875, 850, 800, 750, 700};
   localparam int LO_LIM [8] = '{50, 75, 100, 125, 150, 200, 250, 300};

   logic mclk = 1'b0;
   logic rst, ce, reg_wr, reg_rd, rvalid;
   byte_t reg_addr, reg_wdata, rdata, d;
   threshold_code_t sel;
   level_bus_t pos, neg;
   pin_vec_t pin_in, pin_out, pin_oe, ext, lat, dir;
   channel_vec_t exp_p, exp_n;
   byte_t exp_q[$];
   int num_errors = 0;
   int num_checks = 0;
   int seed = 32'h1eb0;

   always #5 mclk = ~mclk;

   fault_status_and_gpio_regs dut_u (.MCLK(mclk), .RST(rst), .CE(ce), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .COMPARATOR_THRESHOLD_SELECT(sel), .POSITIVE_LEVEL(pos), .NEGATIVE_LEVEL(neg),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

   pin_world pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

   task automatic check(input string what, input byte_t seen, input byte_t expv);
      num_checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
      end
   endtask : check

   // One bus beat per cycle; strobes are held or changed only one cycle apart
   task automatic beat(input logic w, input logic r, input byte_t a, input byte_t wd);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = wd;
      @(posedge mclk);
      #1;
   endtask : beat

   task automatic rd(input byte_t a, input byte_t expv);
      if (ce === 1'b1) exp_q.push_back(expv);
      beat(1'b0, 1'b1, a, 8'h00);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) beat(1'b0, 1'b0, 8'h00, 8'h00);
   endtask : idle

   function automatic channel_vec_t fault_of(input level_bus_t lv, input int code);
      channel_vec_t r;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         r[c] = (int'(lv[c]) > HI_LIM[code]) || (int'(lv[c]) < LO_LIM[code]);
      end
      return r;
   endfunction : fault_of

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // Every read answer is matched against the oldest expectation, half a cycle after it is launched
   always @(negedge mclk) begin
      if (!rst && rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("CHECK FAILED read answer expected none seen %h", rdata);
         end else begin
            check("read data", rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      sel = 3'h0;
      pos = {NUM_CHANNELS{10'h1F4}};
      neg = {NUM_CHANNELS{10'h1F4}};
      ext = 4'h5;
      lat = 4'h0;
      dir = 4'hF;
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      // Back-to-back reads straight out of reset, plus an unmapped offset
      rd(ADDR_POS_STATUS, STATUS_RESET);
      rd(ADDR_NEG_STATUS, STATUS_RESET);
      rd(ADDR_PIN_CTRL, {ext, 4'hF});
      rd(8'h15, READ_UNMAPPED);
      check("pin enable after reset", {4'h0, pin_oe}, 8'h00);
      $display("test reset values done");
      for (int code = 0; code < 8; code++) begin
         sel = threshold_code_t'(code);
         for (int c = 0; c < NUM_CHANNELS; c++) begin
            pos[c] = level_t'($unsigned($random(seed)) % 1001);
            neg[c] = level_t'($unsigned($random(seed)) % 1001);
         end
         // Limits themselves are not faults, one step past them is
         pos[0] = level_t'(HI_LIM[code] + 1);
         pos[1] = level_t'(HI_LIM[code]);
         neg[2] = level_t'(LO_LIM[code] - 1);
         neg[3] = level_t'(LO_LIM[code]);
         neg[7] = level_t'(HI_LIM[code]);
         exp_p = fault_of(pos, code);
         exp_n = fault_of(neg, code);
         idle(2);
         rd(ADDR_POS_STATUS, exp_p);
         rd(ADDR_NEG_STATUS, exp_n);
      end
      // Same levels under the widest window: faults seen only under the narrowest must drop
      sel = 3'h0;
      idle(1);
      rd(ADDR_POS_STATUS, fault_of(pos, 0));
      pos = {NUM_CHANNELS{10'h1F4}};
      neg = {NUM_CHANNELS{10'h1F4}};
      beat(1'b1, 1'b0, ADDR_POS_STATUS, 8'hFF);
      beat(1'b1, 1'b0, ADDR_NEG_STATUS, 8'hFF);
      idle(1);
      rd(ADDR_POS_STATUS, 8'h00);
      rd(ADDR_NEG_STATUS, 8'h00);
      $display("test fault thresholds done");
      // Read and write together return the old direction and the live pins
      exp_q.push_back({ext, dir});
      beat(1'b1, 1'b1, ADDR_PIN_CTRL, 8'hA0);
      dir = 4'h0;
      lat = 4'hA;
      for (int i = 0; i < 16; i++) begin
         d = byte_t'($random(seed));
         ext = pin_vec_t'($random(seed));
         beat(1'b1, 1'b0, ADDR_PIN_CTRL, d);
         dir = d[3:0];
         lat = (lat & dir) | (d[7:4] & ~dir);
         check("pin enable", {4'h0, pin_oe}, {4'h0, ~dir});
         check("pin level", {4'h0, pin_out}, {4'h0, lat});
         rd(ADDR_PIN_CTRL, {(~dir & lat) | (dir & ext), dir});
      end
      // Let the last answer drop first: a frozen clock enable would hold it high
      idle(1);
      // With the clock enable low nothing is taken and nothing answers
      ce = 1'b0;
      beat(1'b1, 1'b0, ADDR_PIN_CTRL, ~d);
      rd(ADDR_PIN_CTRL, 8'h00);
      idle(1);
      check("pin enable frozen", {4'h0, pin_oe}, {4'h0, ~dir});
      check("pin level frozen", {4'h0, pin_out}, {4'h0, lat});
      ce = 1'b1;
      idle(1);
      // A reset in mid-run puts every pin back to input with a clear latch
      rst = 1'b1;
      idle(1);
      rst = 1'b0;
      dir = PIN_CTRL_RESET[DIR_LSB +: NUM_PINS];
      lat = PIN_CTRL_RESET[DATA_LSB +: NUM_PINS];
      check("pin enable after mid-run reset", {4'h0, pin_oe}, {4'h0, ~dir});
      check("pin level after mid-run reset", {4'h0, pin_out}, {4'h0, lat});
      rd(ADDR_PIN_CTRL, {ext, dir});
      $display("test pin control done");
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
         @(posedge mclk);
      end
      if (exp_q.size() > 0) begin
         num_errors++;
         $display("CHECK FAILED read answers outstanding expected 0 seen %0d", exp_q.size());
      end
      end_of_test();
   end
endmodule : fault_status_and_gpio_regs_tb_top
